// file: design/bridge_temp_correction_math.sv
// bridge and temperature correction datapath with serial pin steering
// What this block does
// [RULE1] S-shape: gain times gain factor times offset sum
// [RULE2] S-shape output uses absolute term, offset, bound 2^16
// [RULE3] bridge result delivered as unsigned 0..FFFF
// [RULE4] any clamp sets saturation in status byte
// [RULE5] bridge coefficients are signed 18-bit values
// [RULE6] low-cal reference temperature is signed 17-bit
// [RULE7] raw readings are auto-zeroed signed 18-bit
// [RULE8] temperature always uses parabolic correction
// [RULE9] temperature intermediate: gain, offset, plus half scale
// [RULE10] corrected temperature parabolic, bounded 0..2^17-1
// [RULE11] temperature coefficients are signed 18-bit values
// [RULE12] end-of-conversion output on two identical pads
// [RULE13] host drives interface select pin
// [RULE14] data pin input for SPI, bidirectional for I2C
// [RULE15] shape bit: 0 parabolic, 1 S-shaped
// [RULE16] delta temperature, gain factor, offset sum terms
// [RULE17] saturation shows in status bit 0
// [RULE18] divide by 2^15 as shift before clamp
`timescale 1ns/100ps
module bridge_temp_correction_math (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic conv_start,
  input wire calib_math_pkg::word_t raw_bridge_reading,
  input wire calib_math_pkg::word_t raw_temp_reading,
  input wire calib_math_pkg::coef_t coef,
  input wire logic curve_shape_select,
  output logic busy,
  output logic [15:0] bridge_result,
  output logic [16:0] temp_result,
  output logic [7:0] meas_status,
  output logic eoc1,
  output logic eoc2,
  input wire logic iface_select_pin,
  input wire logic mosi_sda_in,
  output logic mosi_sda_out,
  output logic mosi_sda_oe,
  output logic miso_out,
  output logic i2c_mode,
  output logic serial_rx_bit,
  input wire logic serial_tx_bit,
  input wire logic serial_tx_en
);
  typedef enum logic [3:0] {
    P_IDLE, P_DT, P_K1A, P_K1B, P_K2A, P_K2B, P_Z1, P_Z2,
    P_B1, P_B2, P_T1, P_T2, P_T3, P_T4
  } phase_t;

  typedef struct packed {
    phase_t ph;
    logic shape;
    calib_math_pkg::word_t traw;
    calib_math_pkg::word_t braw;
    calib_math_pkg::word_t dt;
    calib_math_pkg::word_t acc;
    calib_math_pkg::word_t k1;
    calib_math_pkg::word_t k2;
    calib_math_pkg::word_t p;
    calib_math_pkg::word_t z;
    calib_math_pkg::word_t zt;
    logic sat;
    logic [15:0] bridge;
    logic [16:0] temp;
    logic [7:0] status;
    logic eoc;
    logic sel_meta;
    logic sel_s;
    logic sda_meta;
    logic sda_s;
    logic miso;
    logic sda_oe;
  } st_t;

  localparam st_t ST_RESET = '{ph: P_IDLE, default: '0};

  st_t st_r;
  st_t st_nxt;
  calib_math_pkg::word_t m_a;
  calib_math_pkg::word_t m_b;
  calib_math_pkg::sres_t mr;
  calib_math_pkg::sres_t r1;
  calib_math_pkg::sres_t r2;

  mul_shift_sat #(.FRAC(calib_math_pkg::FRAC_BITS)) u_mul (
    .a(m_a),
    .b(m_b),
    .res(mr)
  );

  // magnitude; the most negative code has no positive twin and saturates
  function automatic calib_math_pkg::sres_t abs_sat(input calib_math_pkg::word_t x);
    return calib_math_pkg::clamp18(-calib_math_pkg::widen(x) < 0 ?
      calib_math_pkg::widen(x) : -calib_math_pkg::widen(x));
  endfunction

  function automatic calib_math_pkg::sres_t add_half(input calib_math_pkg::word_t x);
    return calib_math_pkg::clamp18(calib_math_pkg::widen(x) +
      calib_math_pkg::widen(calib_math_pkg::HALF));
  endfunction

  always_comb begin
    st_nxt = st_r;
    m_a = '0;
    m_b = '0;
    r1 = '0;
    r2 = '0;
    // pin samples pass two flops before use
    st_nxt.sel_meta = iface_select_pin; // [RULE13]
    st_nxt.sel_s = st_r.sel_meta;
    st_nxt.sda_meta = mosi_sda_in;
    st_nxt.sda_s = st_r.sda_meta;
    if (st_r.sel_s == calib_math_pkg::SEL_I2C) begin
      st_nxt.miso = 1'b0; // [RULE14]
      st_nxt.sda_oe = serial_tx_en & ~serial_tx_bit; // [RULE14]
    end else begin
      st_nxt.miso = serial_tx_bit; // [RULE14]
      st_nxt.sda_oe = 1'b0; // [RULE14]
    end
    if (st_r.ph != P_IDLE) begin
      st_nxt.sat = st_r.sat | mr.sat; // [RULE4]
    end
    case (st_r.ph)
      P_IDLE: begin
        if (conv_start) begin
          st_nxt.ph = P_DT;
          st_nxt.shape = curve_shape_select; // [RULE15]
          st_nxt.traw = raw_temp_reading; // [RULE7]
          st_nxt.braw = raw_bridge_reading; // [RULE7]
          st_nxt.sat = 1'b0;
          st_nxt.eoc = 1'b0;
        end
      end
      P_DT: begin
        r1 = calib_math_pkg::clamp18(calib_math_pkg::widen(st_r.traw) -
          calib_math_pkg::wide_t'(coef.low_cal_reference_temperature)); // [RULE6] [RULE16]
        st_nxt.dt = r1.val;
        st_nxt.sat = st_r.sat | r1.sat;
        st_nxt.ph = P_K1A;
      end
      P_K1A: begin
        m_a = coef.gain_tc_second_order; // [RULE5]
        m_b = st_r.dt;
        r1 = calib_math_pkg::clamp18(calib_math_pkg::widen(mr.val) +
          calib_math_pkg::widen(coef.tcg)); // [RULE16]
        st_nxt.acc = r1.val;
        st_nxt.sat = st_r.sat | mr.sat | r1.sat;
        st_nxt.ph = P_K1B;
      end
      P_K1B: begin
        m_a = st_r.dt;
        m_b = st_r.acc;
        r1 = add_half(mr.val); // [RULE16]
        st_nxt.k1 = r1.val;
        st_nxt.sat = st_r.sat | mr.sat | r1.sat;
        st_nxt.ph = P_K2A;
      end
      P_K2A: begin
        m_a = coef.offset_tc_second_order;
        m_b = st_r.dt;
        r1 = calib_math_pkg::clamp18(calib_math_pkg::widen(mr.val) +
          calib_math_pkg::widen(coef.tco)); // [RULE16]
        st_nxt.acc = r1.val;
        st_nxt.sat = st_r.sat | mr.sat | r1.sat;
        st_nxt.ph = P_K2B;
      end
      P_K2B: begin
        m_a = st_r.dt;
        m_b = st_r.acc;
        r1 = calib_math_pkg::clamp18(calib_math_pkg::widen(st_r.braw) +
          calib_math_pkg::widen(mr.val)); // [RULE16]
        r2 = calib_math_pkg::clamp18(calib_math_pkg::widen(coef.offset_b) +
          calib_math_pkg::widen(r1.val)); // [RULE16]
        st_nxt.k2 = r2.val;
        st_nxt.sat = st_r.sat | mr.sat | r1.sat | r2.sat;
        st_nxt.ph = P_Z1;
      end
      P_Z1: begin
        m_a = st_r.k1;
        m_b = st_r.k2;
        st_nxt.p = mr.val; // [RULE1]
        st_nxt.ph = P_Z2;
      end
      P_Z2: begin
        m_a = coef.gain_b;
        m_b = st_r.p;
        if (st_r.shape) begin
          st_nxt.z = mr.val; // [RULE1]
        end else begin
          r1 = add_half(mr.val);
          r2 = calib_math_pkg::clamp_rng(calib_math_pkg::widen(r1.val),
            calib_math_pkg::W_ZERO, calib_math_pkg::W_MAX);
          st_nxt.z = r2.val;
          st_nxt.sat = st_r.sat | mr.sat | r1.sat | r2.sat;
        end
        st_nxt.ph = P_B1;
      end
      P_B1: begin
        m_a = coef.bridge_second_order;
        r2 = abs_sat(st_r.z);
        m_b = st_r.shape ? r2.val : st_r.z; // [RULE2]
        r1 = add_half(mr.val); // [RULE2]
        st_nxt.acc = r1.val;
        st_nxt.sat = st_r.sat | mr.sat | r1.sat | (st_r.shape & r2.sat);
        st_nxt.ph = P_B2;
      end
      P_B2: begin
        m_a = st_r.z;
        m_b = st_r.acc;
        if (st_r.shape) begin
          r1 = calib_math_pkg::clamp_rng(calib_math_pkg::widen(mr.val) +
            calib_math_pkg::widen(calib_math_pkg::HALF),
            calib_math_pkg::W_ZERO, calib_math_pkg::W_B_S_MAX); // [RULE2]
        end else begin
          r1 = calib_math_pkg::clamp_rng(calib_math_pkg::widen(mr.val),
            calib_math_pkg::W_ZERO, calib_math_pkg::W_MAX);
        end
        r2 = calib_math_pkg::clamp_rng(calib_math_pkg::widen(r1.val),
          calib_math_pkg::W_ZERO, calib_math_pkg::W_OUT_MAX); // [RULE3]
        st_nxt.bridge = r2.val[15:0]; // [RULE3]
        st_nxt.sat = st_r.sat | mr.sat | r1.sat | r2.sat;
        st_nxt.ph = P_T1;
      end
      P_T1: begin
        r1 = calib_math_pkg::clamp18(calib_math_pkg::widen(st_r.traw) +
          calib_math_pkg::widen(coef.offset_t)); // [RULE9] [RULE11]
        st_nxt.acc = r1.val;
        st_nxt.sat = st_r.sat | r1.sat;
        st_nxt.ph = P_T2;
      end
      P_T2: begin
        m_a = coef.gain_t; // [RULE11]
        m_b = st_r.acc;
        r1 = calib_math_pkg::clamp_rng(calib_math_pkg::widen(mr.val) +
          calib_math_pkg::widen(calib_math_pkg::HALF),
          calib_math_pkg::W_ZERO, calib_math_pkg::W_MAX); // [RULE9]
        st_nxt.zt = r1.val;
        st_nxt.sat = st_r.sat | mr.sat | r1.sat;
        st_nxt.ph = P_T3;
      end
      P_T3: begin
        m_a = coef.temp_second_order; // [RULE8]
        m_b = st_r.zt;
        r1 = add_half(mr.val); // [RULE10]
        st_nxt.acc = r1.val;
        st_nxt.sat = st_r.sat | mr.sat | r1.sat;
        st_nxt.ph = P_T4;
      end
      P_T4: begin
        m_a = st_r.zt;
        m_b = st_r.acc;
        r1 = calib_math_pkg::clamp_rng(calib_math_pkg::widen(mr.val),
          calib_math_pkg::W_ZERO, calib_math_pkg::W_MAX); // [RULE10]
        st_nxt.temp = r1.val[16:0];
        st_nxt.status = '0;
        st_nxt.status[calib_math_pkg::STAT_SAT_BIT] =
          st_r.sat | mr.sat | r1.sat; // [RULE17]
        st_nxt.eoc = 1'b1; // [RULE12]
        st_nxt.ph = P_IDLE;
      end
      default: begin
        st_nxt.ph = P_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st_r <= ST_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign busy = (st_r.ph != P_IDLE);
  assign bridge_result = st_r.bridge;
  assign temp_result = st_r.temp;
  assign meas_status = st_r.status;
  assign eoc1 = st_r.eoc; // [RULE12]
  assign eoc2 = st_r.eoc; // [RULE12]
  assign i2c_mode = (st_r.sel_s == calib_math_pkg::SEL_I2C);
  assign serial_rx_bit = st_r.sda_s;
  assign mosi_sda_out = 1'b0;
  assign mosi_sda_oe = st_r.sda_oe;
  assign miso_out = st_r.miso;

  // helpers seen only by the checks below
  logic seen_sat_r;
  logic s_zero_r;
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      seen_sat_r <= 1'b0;
      s_zero_r <= 1'b0;
    end else if (conv_start && !busy) begin
      seen_sat_r <= 1'b0;
      s_zero_r <= 1'b0;
    end else begin
      if (busy && mr.sat) begin
        seen_sat_r <= 1'b1;
      end
      if (st_r.ph == P_B1) begin
        s_zero_r <= st_r.shape && (st_r.z == '0) && !st_r.sat;
      end
    end
  end

  localparam int CONV_LAT = 14;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  sequence conv_req;
    conv_start && !busy;
  endsequence

  sequence conv_done;
    $rose(eoc1);
  endsequence

  chk_eoc_latency: assert property (conv_req |-> ##CONV_LAT conv_done) // [RULE12]
    else $error("end of conversion not raised 14 cycles after start");
  chk_busy_span: assert property (conv_req |=> busy [*8] ##5 busy ##1 !busy) // [RULE12]
    else $error("busy window of a conversion has wrong length");
  chk_eoc_pads: assert property (eoc1 == eoc2) // [RULE12]
    else $error("end of conversion pads differ");
  chk_sat_status: assert property (conv_done |-> seen_sat_r == 1'b0 || meas_status[0]) // [RULE17]
    else $error("clamp seen in conversion but status bit 0 clear");
  chk_temp_bound: assert property (conv_done |-> temp_result <= 17'h1FFFF &&
    $stable(bridge_result)) // [RULE10]
    else $error("temperature result out of range or bridge changed at end");
  chk_k1_center: assert property (st_r.ph == P_K1B && st_r.dt == '0
    |=> st_r.k1 == calib_math_pkg::HALF) // [RULE16]
    else $error("gain factor not half scale at zero delta temperature");
  chk_s_midscale: assert property (conv_done and s_zero_r
    |-> bridge_result == 16'h8000) // [RULE2]
    else $error("S-shaped zero intermediate did not give mid scale");
  chk_spi_no_drive: assert property (!i2c_mode |=> !mosi_sda_oe) // [RULE14]
    else $error("shared data pin driven in SPI mode");
  chk_i2c_drive: assert property (mosi_sda_oe |-> !mosi_sda_out && !miso_out) // [RULE14]
    else $error("I2C data pin not open drain or MISO active");
endmodule

// file: design/mul_shift_sat.sv
// signed multiply, scale down by 2^frac and clamp to 18 bits
`timescale 1ns/100ps
module mul_shift_sat #(
  parameter int FRAC = calib_math_pkg::FRAC_BITS
) (
  input wire calib_math_pkg::word_t a,
  input wire calib_math_pkg::word_t b,
  output calib_math_pkg::sres_t res
);
  calib_math_pkg::wide_t prod;
  calib_math_pkg::wide_t scaled;

  if (FRAC < 1 || FRAC > 30) begin : g_bad_frac
    $error("mul_shift_sat: FRAC out of range");
  end

  // full product shifted arithmetically before the clamp
  always_comb begin
    prod = calib_math_pkg::widen(a) * calib_math_pkg::widen(b);
    scaled = prod >>> FRAC; // [RULE18]
    res = calib_math_pkg::clamp18(scaled);
  end
endmodule

// file: shared/calib_math_pkg.sv
// shared types, limits and helpers for the correction datapath
package calib_math_pkg;

  localparam int FRAC_BITS = 15;

  typedef logic signed [17:0] word_t;
  typedef logic signed [35:0] wide_t;

  typedef struct packed {
    logic sat;
    word_t val;
  } sres_t;

  typedef struct packed {
    word_t gain_b;
    word_t offset_b;
    word_t tcg;
    word_t tco;
    word_t gain_tc_second_order;
    word_t offset_tc_second_order;
    word_t bridge_second_order;
    logic signed [16:0] low_cal_reference_temperature;
    word_t gain_t;
    word_t offset_t;
    word_t temp_second_order;
  } coef_t;

  // clamp limits, signed 18-bit and final output ranges
  localparam wide_t W_MAX = 36'sh1FFFF;
  localparam wide_t W_MIN = -36'sh20000;
  localparam wide_t W_ZERO = 36'sh0;
  localparam wide_t W_B_S_MAX = 36'sh10000;
  localparam wide_t W_OUT_MAX = 36'sh0FFFF;
  localparam word_t HALF = 18'sh08000;

  localparam int STAT_SAT_BIT = 0;
  localparam logic SEL_I2C = 1'b1;

  function automatic wide_t widen(input word_t x);
    return wide_t'(x);
  endfunction

  function automatic sres_t clamp_rng(input wide_t x, input wide_t lo, input wide_t hi);
    sres_t r;
    r.sat = 1'b0;
    r.val = x[17:0];
    if (x > hi) begin
      r.sat = 1'b1;
      r.val = hi[17:0];
    end else if (x < lo) begin
      r.sat = 1'b1;
      r.val = lo[17:0];
    end
    return r;
  endfunction

  function automatic sres_t clamp18(input wide_t x);
    return clamp_rng(x, W_MIN, W_MAX);
  endfunction

endpackage

// file: sim/bridge_temp_correction_math_test.sv
// self-checking bench for the correction datapath
`timescale 1ns/100ps
module bridge_temp_correction_math_test;
  logic sys_clk, rst, conv_start, curve_shape_select, sel_i2c, host_bit, sat;
  logic serial_tx_bit, serial_tx_en, busy, eoc1, eoc2, mosi_sda_in, mosi_sda_out;
  logic mosi_sda_oe, miso_out, i2c_mode, serial_rx_bit, iface_select_pin;
  logic [15:0] bridge_result;
  logic [16:0] temp_result;
  logic [7:0] meas_status;
  calib_math_pkg::word_t br_val, tr_val, raw_bridge_reading, raw_temp_reading;
  calib_math_pkg::coef_t coef;
  int n_fail = 0;
  int samples_checked = 0;
  int cycles = 0;

  bridge_temp_correction_math dut (.sys_clk(sys_clk), .rst(rst), .conv_start(conv_start),
    .raw_bridge_reading(raw_bridge_reading), .raw_temp_reading(raw_temp_reading),
    .coef(coef), .curve_shape_select(curve_shape_select), .busy(busy),
    .bridge_result(bridge_result), .temp_result(temp_result), .meas_status(meas_status),
    .eoc1(eoc1), .eoc2(eoc2), .iface_select_pin(iface_select_pin),
    .mosi_sda_in(mosi_sda_in), .mosi_sda_out(mosi_sda_out), .mosi_sda_oe(mosi_sda_oe),
    .miso_out(miso_out), .i2c_mode(i2c_mode), .serial_rx_bit(serial_rx_bit),
    .serial_tx_bit(serial_tx_bit), .serial_tx_en(serial_tx_en));
  front_end_model fe (.sel_i2c(sel_i2c), .host_bit(host_bit), .dev_oe(mosi_sda_oe),
    .busy(busy), .br_val(br_val), .tr_val(tr_val), .iface_select_pin(iface_select_pin),
    .mosi_sda_in(mosi_sda_in), .raw_bridge_reading(raw_bridge_reading),
    .raw_temp_reading(raw_temp_reading));

  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      n_fail++;
      finish_test();
    end
  end

  task automatic chk(input string what, input logic [17:0] exp, input logic [17:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  task automatic chk_bit(input string what, input logic exp, input logic got);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected %s expected %b seen %b", what, exp, got);
    end
  endtask

  // clamp and note saturation
  function automatic longint cl(longint x, longint lo = -131072, longint hi = 131071);
    if (x > hi || x < lo) sat = 1'b1;
    return (x > hi) ? hi : (x < lo) ? lo : x;
  endfunction

  function automatic longint ms(longint a, longint b);
    return cl((a * b) >>> 15);
  endfunction

  task automatic ref_vals(output longint eb, output longint et);
    longint b, t, dt, k1, k2, z;
    b = br_val;
    t = tr_val;
    sat = 1'b0;
    dt = cl(t - coef.low_cal_reference_temperature);
    k1 = cl(32768 + ms(dt, cl(ms(coef.gain_tc_second_order, dt) + coef.tcg)));
    k2 = ms(dt, cl(ms(coef.offset_tc_second_order, dt) + coef.tco));
    k2 = cl(coef.offset_b + cl(b + k2));
    z = ms(coef.gain_b, ms(k1, k2));
    if (curve_shape_select) begin
      eb = cl(ms(coef.bridge_second_order, cl(z < 0 ? -z : z)) + 32768);
      eb = cl(ms(z, eb) + 32768, 0, 65536);
    end else begin
      z = cl(z + 32768, 0, 131071);
      eb = cl(ms(z, cl(ms(coef.bridge_second_order, z) + 32768)), 0, 131071);
    end
    eb = cl(eb, 0, 65535);
    z = cl(ms(coef.gain_t, cl(t + coef.offset_t)) + 32768, 0, 131071);
    et = cl(ms(z, cl(ms(coef.temp_second_order, z) + 32768)), 0, 131071);
  endtask

  // one conversion; poke raises a start request while busy
  task automatic run(input logic mode, input logic [17:0] b, input logic [17:0] t,
                     input logic poke);
    longint eb, et;
    curve_shape_select = mode;
    br_val = b;
    tr_val = t;
    ref_vals(eb, et);
    conv_start = 1'b1;
    @(negedge sys_clk);
    chk_bit("busy", 1'b1, busy);
    chk_bit("eoc1", 1'b0, eoc1);
    for (int i = 0; i < 12; i++) begin
      conv_start = poke && i == 4;
      @(negedge sys_clk);
    end
    chk_bit("eoc1", 1'b0, eoc1);
    @(negedge sys_clk);
    chk_bit("eoc1", 1'b1, eoc1);
    chk_bit("eoc2", 1'b1, eoc2);
    chk_bit("busy", 1'b0, busy);
    chk("bridge", eb[17:0], 18'(bridge_result));
    chk("temp", et[17:0], 18'(temp_result));
    chk("status", 18'({7'h0, sat}), 18'(meas_status));
  endtask

  task automatic do_reset();
    rst = 1'b1;
    // exactly two rising edges under reset, released on a falling edge
    repeat (2) @(posedge sys_clk);
    @(negedge sys_clk);
    rst = 1'b0;
    chk_bit("busy", 1'b0, busy);
    chk_bit("eoc1", 1'b0, eoc1);
    chk_bit("sda_oe", 1'b0, mosi_sda_oe);
    chk_bit("i2c_mode", 1'b0, i2c_mode);
    chk("bridge", 18'h0, 18'(bridge_result));
    chk("status", 18'h0, 18'(meas_status));
  endtask

  task automatic pins(input logic sel, input logic en, input logic txb, input logic hb,
                      input logic oe, input logic mi, input logic rx);
    sel_i2c = sel;
    serial_tx_en = en;
    serial_tx_bit = txb;
    host_bit = hb;
    // select needs two flops and the drive one more; a pulled-low line
    // then needs two more flops before it shows on the receive bit
    repeat (5) @(negedge sys_clk);
    chk_bit("i2c_mode", sel, i2c_mode);
    chk_bit("sda_oe", oe, mosi_sda_oe);
    chk_bit("miso", mi, miso_out);
    chk_bit("rx", rx, serial_rx_bit);
    chk_bit("sda_out", 1'b0, mosi_sda_out);
  endtask

  initial begin
    rst = 1'b1;
    conv_start = 1'b0;
    curve_shape_select = 1'b0;
    sel_i2c = 1'b0;
    host_bit = 1'b1;
    serial_tx_bit = 1'b0;
    serial_tx_en = 1'b0;
    br_val = 18'sh0;
    tr_val = 18'sh0;
    sat = 1'b0;
    coef = '0;
    do_reset();
    coef = '{18'sh08000, 18'sh00400, 18'sh00200, 18'sh3FE00, 18'sh00100, 18'sh3FF00,
             18'sh00800, 17'sh00100, 18'sh08000, 18'sh00100, 18'sh00200};
    run(1'b0, 18'h01000, 18'h00500, 1'b0);
    run(1'b1, 18'h3F000, 18'h3FB00, 1'b1);
    run(1'b1, 18'h00000, 18'h3FB00, 1'b0);
    coef = '{18'sh1FFFF, 18'sh1FFFF, 18'sh1FFFF, 18'sh1FFFF, 18'sh1FFFF, 18'sh1FFFF,
             18'sh1FFFF, 17'sh10001, 18'sh1FFFF, 18'sh1FFFF, 18'sh1FFFF};
    run(1'b0, 18'h1FFFF, 18'h1FFFF, 1'b0);
    coef = '{18'sh20001, 18'sh20001, 18'sh20001, 18'sh20001, 18'sh20001, 18'sh20001,
             18'sh20001, 17'sh0FFFF, 18'sh20001, 18'sh20001, 18'sh20001};
    run(1'b1, 18'h20001, 18'h20001, 1'b0);
    run(1'b0, 18'h20001, 18'h20001, 1'b0);
    coef = '{18'sh3C000, 18'sh00000, 18'sh00000, 18'sh00000, 18'sh00000, 18'sh00000,
             18'sh04000, 17'sh00000, 18'sh08000, 18'sh00000, 18'sh00000};
    run(1'b1, 18'h02000, 18'h00010, 1'b0);
    // zero delta and zero bridge: unit gain factor and a mid-scale S result
    run(1'b1, 18'h00000, 18'h00000, 1'b0);
    pins(1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0);
    pins(1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1);
    pins(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
    pins(1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1);
    pins(1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
    do_reset();
    run(1'b0, 18'h00800, 18'h00040, 1'b0);
    finish_test();
  end
endmodule

// file: sim/front_end_model.sv
// adc front end and host serial side model
`timescale 1ns/100ps
module front_end_model (
  input wire logic sel_i2c,
  input wire logic host_bit,
  input wire logic dev_oe,
  input wire logic busy,
  input wire calib_math_pkg::word_t br_val,
  input wire calib_math_pkg::word_t tr_val,
  output logic iface_select_pin,
  output logic mosi_sda_in,
  output calib_math_pkg::word_t raw_bridge_reading,
  output calib_math_pkg::word_t raw_temp_reading
);
  assign iface_select_pin = sel_i2c;
  // pull-up on the shared line in i2c mode, plain data input in spi mode
  assign mosi_sda_in = sel_i2c ? (host_bit & !dev_oe) : host_bit;
  // readings are valid only while idle, garbage while converting
  assign raw_bridge_reading = busy ? ~br_val : br_val;
  assign raw_temp_reading = busy ? ~tr_val : tr_val;
endmodule
